// >>> design/srwcd_top.sv
// Sector read/write command handler of a mass storage controller.
// Assumes the host streams command bytes in order and a media engine
// serves physical sector reads and writes one byte at a time.
// Operation
// R01 - Read command is exactly four bytes: opcode and three address bytes.
// R02 - Read returns status byte, then whole sector: one plus sector size.
// R03 - Read opcodes 12h,02h/22h,32h,42h(tape) select 128,256,512,1024 bytes.
// R04 - Write opcodes 13h,03h/23h,33h,43h(tape) select 128,256,512,1024 bytes.
// R05 - Write carries opcode, address, data from offset four; one result byte.
// R06 - Twenty-bit variant: low nibble of first byte is drive, 1 to 15.
// R07 - Twenty-bit variant: high nibble of first byte is top address nibble.
// R08 - Second byte is address low byte, third byte the middle byte.
// R09 - Twenty-four-bit variant: swap nibbles, subtract 10h, use as top byte.
// R10 - For drive one and short addresses both variants decode identically.
// R11 - Address counts in units of the opcode's sector size.
// R12 - With verify on, read back written sector and check its CRC.
// R13 - With verify off, no read-back after a media write.
// R14 - Verify choice is one configuration byte; default means no verify.
// R15 - Twenty-bit variant always verifies, tape variant never verifies.
// R16 - Writes smaller than physical sector read, merge, then write back.
// R17 - Tape variant always reports success code zero for writes; code reports FFh when the merge read before the write fails.
// R18 - On an error only the single status byte is returned.
// R19 - Command and result bytes move in ascending offset order.
`timescale 1ns/100ps
module srwcd_top import srwcd_pkg::*; (
  input wire logic clock, // 50 MHz clock
  input wire logic nrst, // Async reset, active low
  input wire srwcd_variant_e variant, // Controller variant
  input wire logic [7:0] verify_cfg, // Verify config byte, nonzero = verify on 24-bit variant only
  input wire logic [7:0] cmd_data, // Command byte from host
  input wire logic cmd_valid, // Command byte valid
  output logic cmd_ready, // Command byte accepted
  output logic [7:0] res_data, // Result byte to host
  output logic res_valid, // Result byte valid
  input wire logic res_ready, // Host takes result byte
  output logic [23:0] med_addr, // Physical sector number
  output logic med_rd_req, // Media read request, pulse
  output logic med_wr_req, // Media write request, pulse
  output logic [10:0] med_idx, // Byte index in physical sector
  input wire logic [7:0] med_rd_data, // Byte read from media
  output logic [7:0] med_wr_data, // Byte for media write
  input wire logic med_done, // Media operation finished, pulse
  input wire logic med_err, // Media error, with done
  input wire logic med_crc_ok, // CRC good, with done of a read
  output logic busy // Command in progress
);
  // Every command returns to ST_OPC through ST_DRAIN
  typedef enum logic [3:0] {
    ST_OPC, // Idle, awaiting opcode
    ST_ADR, // Address bytes
    ST_DATA, // Write data into its chunk
    ST_CHK, // Check command, settle address
    ST_MRD, // Physical sector read
    ST_MWR, // Physical sector write
    ST_VFY, // Read-back after write
    ST_STAT, // Status byte
    ST_SEND, // Sector chunk
    ST_DRAIN // Host empties the buffer
  } srwcd_state_e;

  srwcd_state_e state_q;
  logic [7:0] opc_q;
  logic [23:0] field_q;
  logic [1:0] hcnt_q;
  logic is_wr_q;
  logic [10:0] size_q;
  logic [10:0] cnt_q;
  logic [10:0] base_q;
  logic [23:0] phys_q;
  logic [7:0] status_q;
  logic [7:0] sec_q [1024];
  logic [7:0] verify_q;
  logic req_q;
  logic [7:0] ob_data;
  logic ob_valid;
  logic ob_ready;
  logic [23:0] sec_addr;
  logic drive_ok;
  srwcd_size_e sz;
  logic [10:0] sz_bytes;
  logic [10:0] phys_bytes;
  logic do_verify;
  logic [34:0] byte_addr;
  logic [10:0] chunk_off;
  logic in_chunk;

  // ****************************************************************
  // Opcode decode
  // ****************************************************************
  // 1024-byte opcodes exist only on the tape variant
  function automatic srwcd_size_e op_size(input logic [7:0] op, input srwcd_variant_e v);
    srwcd_size_e s;
    s = SRWCD_SZ_NONE;
    case (op)
      `SRWCD_OP_RD128, `SRWCD_OP_WR128: s = SRWCD_SZ_128; // R03 R04
      `SRWCD_OP_RD256A, `SRWCD_OP_RD256B, `SRWCD_OP_WR256A, `SRWCD_OP_WR256B: s = SRWCD_SZ_256; // R03 R04
      `SRWCD_OP_RD512, `SRWCD_OP_WR512: s = SRWCD_SZ_512; // R03 R04
      `SRWCD_OP_RD1024, `SRWCD_OP_WR1024: s = (v == SRWCD_VTAPE) ? SRWCD_SZ_1024 : SRWCD_SZ_NONE; // R03 R04
      default: s = SRWCD_SZ_NONE;
    endcase
    return s;
  endfunction

  // Byte count of a size code; zero marks a refused opcode
  function automatic logic [10:0] size_bytes(input srwcd_size_e s);
    logic [10:0] n;
    n = 11'h000;
    unique case (s)
      SRWCD_SZ_NONE: n = 11'h000;
      SRWCD_SZ_128: n = 11'h080;
      SRWCD_SZ_256: n = 11'h100;
      SRWCD_SZ_512: n = 11'h200;
      SRWCD_SZ_1024: n = 11'h400;
    endcase
    return n;
  endfunction

  // Geometry of the current command
  assign sz = op_size(opc_q, variant);
  assign sz_bytes = size_bytes(sz);
  assign phys_bytes = (variant == SRWCD_VTAPE) ? `SRWCD_TAPE_PHYS_BYTES : `SRWCD_PHYS_BYTES;
  // Address is in logical sector units; scale to bytes then to physical
  assign byte_addr = {11'h000, sec_addr} * {24'h000000, sz_bytes}; // R11
  // Where the addressed chunk sits inside its physical sector
  assign chunk_off = 11'(byte_addr % {24'h000000, phys_bytes}); // R11 R16
  // Merge read must not overwrite the bytes the host sent
  assign in_chunk = (cnt_q >= base_q) && (cnt_q < base_q + size_q); // R16
  // Fixed variants override the configuration byte
  assign do_verify = (variant == SRWCD_V20) ? 1'b1 :
                     (variant == SRWCD_VTAPE) ? 1'b0 : (verify_q != `SRWCD_VERIFY_CFG_RST); // R14 R15

  // Drive number is only needed for the range check
  srwcd_addr_dec u_dec (
    .sector_address_field(field_q),
    .variant(variant),
    .sector_addr(sec_addr),
    .drive_num(),
    .drive_ok(drive_ok)
  );

  // Host stalls never drop a result byte
  srwcd_buf2 u_obuf (
    .clock(clock),
    .nrst(nrst),
    .in_data(ob_data),
    .in_valid(ob_valid),
    .in_ready(ob_ready),
    .out_data(res_data),
    .out_valid(res_valid),
    .out_ready(res_ready)
  );

  // Handshakes and media port
  assign cmd_ready = (state_q == ST_OPC) || (state_q == ST_ADR) || (state_q == ST_DATA);
  assign busy = (state_q != ST_OPC);
  assign med_idx = cnt_q;
  assign med_wr_data = sec_q[cnt_q[9:0]];
  assign med_rd_req = req_q && ((state_q == ST_MRD) || (state_q == ST_VFY));
  assign med_wr_req = req_q && (state_q == ST_MWR);
  assign med_addr = phys_q;

  // Result stream: status first, then the requested chunk in order
  always_comb begin
    ob_valid = 1'b0;
    ob_data = status_q;
    if (state_q == ST_STAT) begin
      ob_valid = 1'b1; // R19
    end else if (state_q == ST_SEND) begin
      ob_valid = 1'b1;
      ob_data = sec_q[10'(base_q + cnt_q)]; // R02 R19
    end
  end

  // ****************************************************************
  // Configuration byte
  // ****************************************************************
  // Reloaded in every idle cycle in ST_OPC; default selects no verify
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) verify_q <= `SRWCD_VERIFY_CFG_RST; // R14
    else if (state_q == ST_OPC) verify_q <= verify_cfg; // R14
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_OPC;
      opc_q <= 8'h00;
      field_q <= 24'h000000;
      hcnt_q <= 2'h0;
      is_wr_q <= 1'b0;
      size_q <= 11'h000;
      cnt_q <= 11'h000;
      base_q <= 11'h000;
      phys_q <= 24'h000000;
      status_q <= `SRWCD_RES_OK;
      req_q <= 1'b0;
    end else begin
      req_q <= 1'b0;
      // Requests last one cycle unless a branch raises them
      unique case (state_q)
        // Bit 0 of the opcode marks a write
        ST_OPC: if (cmd_valid) begin
          opc_q <= cmd_data; // R19
          is_wr_q <= cmd_data[0];
          hcnt_q <= 2'h1;
          state_q <= ST_ADR;
        end
        ST_ADR: if (cmd_valid) begin
          field_q <= {field_q[15:0], cmd_data}; // R01 R19
          hcnt_q <= hcnt_q + 2'h1;
          if (hcnt_q == 2'(`SRWCD_HDR_LEN - 11'h001)) begin
            size_q <= sz_bytes;
            cnt_q <= 11'h000;
            // An unknown size gives no data length, so refuse at once
            state_q <= (is_wr_q && sz_bytes != 11'h000) ? ST_DATA : ST_CHK; // R01 R05
          end
        end
        ST_DATA: if (cmd_valid) begin
          // Data held at the chunk offset for a later merge
          cnt_q <= cnt_q + 11'h001;
          if (cnt_q == size_q - 11'h001) begin
            cnt_q <= 11'h000;
            state_q <= ST_CHK; // R05
          end
        end
        ST_CHK: begin
          // Address is registered before the request so both leave together
          phys_q <= 24'(byte_addr / {24'h000000, phys_bytes}); // R11
          base_q <= chunk_off; // R11
          cnt_q <= 11'h000;
          if (size_q == 11'h000 || !drive_ok) begin
            status_q <= `SRWCD_RES_BAD_CMD;
            state_q <= ST_STAT; // R18
          end else if (is_wr_q && size_q == phys_bytes) begin
            // A whole physical sector needs no read first
            state_q <= ST_MWR; // R16
            req_q <= 1'b1;
          end else begin
            state_q <= ST_MRD; // R02 R16
            req_q <= 1'b1;
          end
        end
        ST_MRD: begin
          // One byte a cycle, from the cycle after the request
          if (!req_q && !med_done) cnt_q <= cnt_q + 11'h001;
          if (med_done) begin
            cnt_q <= 11'h000;
            status_q <= med_err ? 8'hFF : `SRWCD_RES_OK;
            if (med_err) state_q <= ST_STAT; // R18
            else if (is_wr_q) begin
              state_q <= ST_MWR; // R16
              req_q <= 1'b1;
            end else state_q <= ST_STAT; // R02
          end
        end
        ST_MWR: begin
          // Same pacing as the read, so med_idx walks the sector
          if (!req_q && !med_done) cnt_q <= cnt_q + 11'h001;
          if (med_done) begin
            cnt_q <= 11'h000;
            status_q <= med_err ? 8'hFF : `SRWCD_RES_OK;
            if (variant == SRWCD_VTAPE) status_q <= `SRWCD_RES_OK; // R17
            if (!med_err && do_verify) begin
              state_q <= ST_VFY; // R12
              req_q <= 1'b1;
            end else state_q <= ST_STAT; // R13
          end
        end
        // A bad read-back CRC fails the write
        ST_VFY: if (med_done) begin
          if (med_err || !med_crc_ok) status_q <= 8'hFF; // R12
          state_q <= ST_STAT;
        end
        ST_STAT: if (ob_ready) begin
          cnt_q <= 11'h000;
          // Writes and errors answer with the one byte only
          state_q <= (is_wr_q || status_q != `SRWCD_RES_OK) ? ST_DRAIN : ST_SEND; // R05 R18
        end
        // One chunk byte each time the buffer has room
        ST_SEND: if (ob_ready) begin
          cnt_q <= cnt_q + 11'h001;
          if (cnt_q == size_q - 11'h001) state_q <= ST_DRAIN; // R02
        end
        // A new opcode never overtakes a queued result
        ST_DRAIN: if (!res_valid) state_q <= ST_OPC;
      endcase
    end
  end

  // ****************************************************************
  // Sector buffer
  // ****************************************************************
  // Read fills the physical image; write data overlays its chunk (merge)
  // The merge read skips the chunk so host data survives
  always_ff @(posedge clock) begin
    if (state_q == ST_DATA && cmd_valid) begin
      sec_q[10'(chunk_off + cnt_q)] <= cmd_data; // R05 R16
    end else if (state_q == ST_MRD && !req_q && !med_done && !(is_wr_q && in_chunk)) begin
      sec_q[cnt_q[9:0]] <= med_rd_data; // R16
    end
  end
endmodule

// >>> design/srwcd_params.svh
// Constants for the sector read/write command handler.
// Assumes inclusion by the package and test modules by bare name.
`ifndef SRWCD_PARAMS_SVH
`define SRWCD_PARAMS_SVH
// ****************************************************************
// Opcodes
// ****************************************************************
`define SRWCD_OP_RD256A 8'h02
`define SRWCD_OP_RD128 8'h12
`define SRWCD_OP_RD256B 8'h22
`define SRWCD_OP_RD512 8'h32
`define SRWCD_OP_RD1024 8'h42
`define SRWCD_OP_WR256A 8'h03
`define SRWCD_OP_WR128 8'h13
`define SRWCD_OP_WR256B 8'h23
`define SRWCD_OP_WR512 8'h33
`define SRWCD_OP_WR1024 8'h43
// ****************************************************************
// Lengths, offsets, codes
// ****************************************************************
`define SRWCD_HDR_LEN 11'h004
`define SRWCD_PHYS_BYTES 11'h200
`define SRWCD_TAPE_PHYS_BYTES 11'h400
`define SRWCD_ADDR_MSB_BIAS 8'h10
`define SRWCD_RES_OK 8'h00
`define SRWCD_RES_BAD_CMD 8'h80
`define SRWCD_VERIFY_CFG_RST 8'h00
`endif

// >>> design/srwcd_pkg.sv
// Types shared by the sector read/write command handler.
// Assumes srwcd_params.svh is on the include path.
package srwcd_pkg;
  `include "srwcd_params.svh"

  // Addressing variant of the controller
  typedef enum logic [1:0] {
    SRWCD_V20,
    SRWCD_V24,
    SRWCD_VTAPE
  } srwcd_variant_e;

  // Sector size selected by the opcode
  typedef enum logic [2:0] {
    SRWCD_SZ_NONE,
    SRWCD_SZ_128,
    SRWCD_SZ_256,
    SRWCD_SZ_512,
    SRWCD_SZ_1024
  } srwcd_size_e;
endpackage

// >>> design/srwcd_buf2.sv
// Two-entry byte buffer with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module srwcd_buf2 import srwcd_pkg::*; (
  input wire logic clock, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [7:0] in_data, // Fill data
  input wire logic in_valid, // Fill valid
  output logic in_ready, // Room for a byte
  output logic [7:0] out_data, // Head byte, registered
  output logic out_valid, // Head valid
  input wire logic out_ready // Drain accepts
);
  logic [7:0] mem_q [2];
  logic rd_q;
  logic wr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  // ****************************************************************
  // Handshakes
  // ****************************************************************
  // Two entries so a stalled receiver never drops a word
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  // Storage
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
    end else if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// >>> design/srwcd_addr_dec.sv
// Sector address field decoder for both addressing variants.
// Pure combinational; caller registers the results.
`timescale 1ns/100ps
module srwcd_addr_dec import srwcd_pkg::*; (
  input wire logic [23:0] sector_address_field, // Bytes 1..3 as {b1,b2,b3}
  input wire srwcd_variant_e variant, // Addressing variant
  output logic [23:0] sector_addr, // Decoded sector number
  output logic [3:0] drive_num, // Drive number, 20-bit variant
  output logic drive_ok // Drive number in 1..15 on 20-bit variant, always 1 otherwise
);
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;
  logic [7:0] swapped;

  assign b1 = sector_address_field[23:16];
  assign b2 = sector_address_field[15:8];
  assign b3 = sector_address_field[7:0];
  assign swapped = {b1[3:0], b1[7:4]};

  // ****************************************************************
  // Decode
  // ****************************************************************
  // With drive 1 and a 20-bit address both paths give the same number
  always_comb begin
    drive_num = 4'h0;
    drive_ok = 1'b1;
    if (variant == SRWCD_V20) begin
      drive_num = b1[3:0]; // R06
      drive_ok = (b1[3:0] != 4'h0); // R06
      sector_addr = {4'h0, b1[7:4], b3, b2}; // R07 R08 R10
    end else begin
      sector_addr = {swapped - `SRWCD_ADDR_MSB_BIAS, b3, b2}; // R09 R08 R10
    end
  end
endmodule

// >>> test/srwcd_top_monitor.sv
// Port checker for the sector command handler.
// Assumes one clock and nrst asynchronous, active low.
`timescale 1ns/100ps
`include "srwcd_params.svh"
module srwcd_top_monitor import srwcd_pkg::*; (
  input wire logic clock, // Clock
  input wire logic nrst, // Reset, active low
  input wire srwcd_variant_e variant, // Variant
  input wire logic cmd_valid, // Command valid
  input wire logic cmd_ready, // Command ready
  input wire logic [7:0] res_data, // Result byte
  input wire logic res_valid, // Result valid
  input wire logic res_ready, // Result taken
  input wire logic med_rd_req, // Media read
  input wire logic med_wr_req, // Media write
  input wire logic busy // Busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Marks a command that has written the media
  logic wr_seen_q;
  always_ff @(posedge clock or negedge nrst)
    if (!nrst) wr_seen_q <= 1'b0;
    else if (!busy) wr_seen_q <= 1'b0;
    else if (med_wr_req) wr_seen_q <= 1'b1;
  // ****
  // Properties
  // ****
  a_req_pulse: assert property ((med_rd_req || med_wr_req) |=> !med_rd_req && !med_wr_req)
    else $error("media request longer than one cycle");
  a_req_single: assert property (!(med_rd_req && med_wr_req))
    else $error("read and write requested together");
  a_res_hold: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
    else $error("result byte lost while stalled");
  a_idle_quiet: assert property (!busy |-> !res_valid && !med_rd_req && !med_wr_req)
    else $error("activity while idle");
  a_idle_ready: assert property (!busy |-> cmd_ready)
    else $error("idle handler refuses an opcode");
  a_cmd_start: assert property (!busy && cmd_valid && cmd_ready |=> busy)
    else $error("opcode taken without starting");
  a_v20_verify: assert property (variant == SRWCD_V20 && med_wr_req |-> ##[1:1000] med_rd_req)
    else $error("no read back on twenty-bit variant");
  a_tape_nover: assert property (wr_seen_q && variant == SRWCD_VTAPE |-> !med_rd_req)
    else $error("read after write on tape variant");
  a_tape_ok: assert property (wr_seen_q && variant == SRWCD_VTAPE && res_valid |-> res_data == `SRWCD_RES_OK)
    else $error("tape write status not zero");
  c_read: cover property (med_rd_req);
  c_write: cover property (med_wr_req);
  c_refuse: cover property (res_valid && res_data == `SRWCD_RES_BAD_CMD);
  c_stall: cover property (res_valid && !res_ready);
endmodule
bind srwcd_top srwcd_top_monitor u_mon (.clock, .nrst, .variant, .cmd_valid, .cmd_ready, .res_data,
  .res_valid, .res_ready, .med_rd_req, .med_wr_req, .busy);

// >>> test/srwcd_media_model.sv
// Behavioural media engine for the sector command handler.
// Assumes one-cycle requests and one byte a cycle per operation.
`timescale 1ns/100ps
`include "srwcd_params.svh"
module srwcd_media_model import srwcd_pkg::*; (
  input wire logic clock, // Clock
  input wire logic nrst, // Reset, active low
  input wire srwcd_variant_e variant, // Sets sector length
  input wire logic [23:0] med_addr, // Physical sector
  input wire logic med_rd_req, // Read request
  input wire logic med_wr_req, // Write request
  input wire logic [10:0] med_idx, // Byte index
  input wire logic [7:0] med_wr_data, // Byte to store
  output logic [7:0] med_rd_data, // Byte served
  output logic med_done, // Operation over
  output logic med_err, // Media fault
  output logic med_crc_ok, // Read CRC good
  input wire logic err_en, // Report a fault
  input wire logic crc_bad, // Report bad CRC
  output logic [15:0] rd_count, // Reads seen
  output logic [15:0] wr_count, // Writes seen
  output logic [23:0] last_addr // Last read sector
);
  logic [7:0] mem [0:1023];
  logic [23:0] addr_q;
  logic [23:0] mem_addr_q;
  logic mem_ok_q;
  logic wr_q;
  logic [10:0] left_q;
  // Inverted between operations so stale bytes never look right
  always_comb begin
    if (mem_ok_q && addr_q == mem_addr_q) med_rd_data = mem[med_idx[9:0]];
    else med_rd_data = addr_q[7:0] ^ med_idx[7:0] ^ {5'h00, med_idx[10:8]};
    if (left_q == 11'h000) med_rd_data = ~med_rd_data;
  end
  assign med_err = med_done & err_en;
  assign med_crc_ok = med_done & ~crc_bad;
  // Whole physical sector per operation
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      left_q <= 11'h000;
      med_done <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 24'h000000;
      rd_count <= 16'h0000;
      wr_count <= 16'h0000;
      last_addr <= 24'h000000;
    end else begin
      med_done <= left_q == 11'h001;
      if (med_rd_req || med_wr_req) begin
        left_q <= (variant == SRWCD_VTAPE) ? `SRWCD_TAPE_PHYS_BYTES : `SRWCD_PHYS_BYTES;
        wr_q <= med_wr_req;
        addr_q <= med_addr;
        rd_count <= rd_count + 16'(med_rd_req);
        wr_count <= wr_count + 16'(med_wr_req);
        if (med_rd_req) last_addr <= med_addr;
      end else if (left_q != 11'h000) left_q <= left_q - 11'h001;
    end
  end
  // Keeps the last written sector so merges and read-back show
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mem_ok_q <= 1'b0;
      mem_addr_q <= 24'h000000;
    end else if (med_wr_req) begin
      mem_ok_q <= 1'b1;
      mem_addr_q <= med_addr;
    end
  end
  always_ff @(posedge clock) if (wr_q && left_q != 11'h000) mem[med_idx[9:0]] <= med_wr_data;
endmodule

// >>> test/srwcd_top_tb.sv
// Self-checking bench for the sector command handler.
// Assumes the media model on the media port and the bound checker.
`timescale 1ns/100ps
`include "srwcd_params.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module srwcd_top_tb import srwcd_pkg::*; ;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  srwcd_variant_e variant = SRWCD_V24;
  logic [7:0] verify_cfg = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_valid = 1'b0;
  logic res_ready = 1'b0;
  logic err_en = 1'b0;
  logic crc_bad = 1'b0;
  logic cmd_ready, res_valid, med_rd_req, med_wr_req, med_done, med_err, med_crc_ok, busy;
  logic [7:0] res_data, med_rd_data, med_wr_data;
  logic [23:0] med_addr, last_addr;
  logic [10:0] med_idx;
  logic [15:0] rd_count, wr_count;
  logic [23:0] mp = 24'hFFFFFF;
  int mlo = 0;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  srwcd_top u_dut (.clock, .nrst, .variant, .verify_cfg, .cmd_data, .cmd_valid, .cmd_ready, .res_data,
    .res_valid, .res_ready, .med_addr, .med_rd_req, .med_wr_req, .med_idx, .med_rd_data, .med_wr_data,
    .med_done, .med_err, .med_crc_ok, .busy);
  srwcd_media_model u_media (.clock, .nrst, .variant, .med_addr, .med_rd_req, .med_wr_req, .med_idx,
    .med_wr_data, .med_rd_data, .med_done, .med_err, .med_crc_ok, .err_en, .crc_bad, .rd_count,
    .wr_count, .last_addr);
  always #10 clock = ~clock;
  // Host stalls one cycle in three so the buffer must hold bytes
  always @(posedge clock) begin
    cyc <= cyc + 1;
    res_ready <= (cyc % 3) != 2;
  end
  // ****
  // Helpers
  // ****
  function automatic logic [7:0] expb(input logic [23:0] p, input logic [10:0] i);
    if (p === mp && i >= mlo && i < mlo + 128) return 8'(i - mlo) ^ 8'h5A;
    return p[7:0] ^ i[7:0] ^ {5'h00, i[10:8]};
  endfunction
  task automatic send(input logic [7:0] b);
    int n = 0;
    cmd_data <= b;
    cmd_valid <= 1'b1;
    @(negedge clock);
    while (cmd_ready !== 1'b1 && n < 3000) begin @(negedge clock); n++; end
    `CHK("cmd_ready", 1'b1, cmd_ready)
    @(posedge clock);
  endtask
  task automatic take(input logic [7:0] e, input string nm);
    int n = 0;
    @(negedge clock);
    while (!(res_valid === 1'b1 && res_ready === 1'b1) && n < 5000) begin @(negedge clock); n++; end
    `CHK(nm, e, res_data)
    @(posedge clock);
  endtask
  task automatic idle_chk();
    repeat (4) @(negedge clock);
    `CHK("res_valid", 1'b0, res_valid)
    `CHK("busy", 1'b0, busy)
    @(posedge clock);
  endtask
  task automatic cmd(input srwcd_variant_e v, input logic [7:0] op, b1, b2, b3);
    variant <= v;
    @(posedge clock);
    send(op);
    send(b1);
    send(b2);
    send(b3);
  endtask
  task automatic rd(input srwcd_variant_e v, input logic [7:0] op, b1, b2, b3, st,
      input logic [23:0] pa, input int off, sz);
    cmd(v, op, b1, b2, b3);
    cmd_valid <= 1'b0;
    take(st, "status");
    if (st === `SRWCD_RES_OK) begin
      `CHK("med_addr", pa, last_addr)
      for (int i = 0; i < sz; i++) take(expb(pa, 11'(off + i)), "data");
    end
    idle_chk();
  endtask
  task automatic wr(input srwcd_variant_e v, input logic [7:0] op, b1, b2, b3, vc, st,
      input int sz, drd, dwr);
    int r0, w0;
    verify_cfg <= vc;
    r0 = rd_count;
    w0 = wr_count;
    cmd(v, op, b1, b2, b3);
    for (int k = 0; k < sz; k++) send(8'(k) ^ 8'h5A);
    cmd_valid <= 1'b0;
    take(st, "write status");
    `CHK("media reads", 16'(drd), 16'(rd_count - r0))
    `CHK("media writes", 16'(dwr), 16'(wr_count - w0))
    idle_chk();
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_sizes();
    rd(SRWCD_V24, `SRWCD_OP_RD256A, 8'h01, 8'h10, 8'h00, 8'h00, 24'h000008, 0, 256);
    rd(SRWCD_V24, `SRWCD_OP_RD128, 8'h01, 8'h20, 8'h00, 8'h00, 24'h000008, 0, 128);
    rd(SRWCD_V24, `SRWCD_OP_RD256B, 8'h01, 8'h10, 8'h00, 8'h00, 24'h000008, 0, 256);
    rd(SRWCD_V24, `SRWCD_OP_RD512, 8'h01, 8'h08, 8'h00, 8'h00, 24'h000008, 0, 512);
    rd(SRWCD_V24, `SRWCD_OP_RD128, 8'h01, 8'h21, 8'h00, 8'h00, 24'h000008, 128, 128);
    rd(SRWCD_VTAPE, `SRWCD_OP_RD1024, 8'h01, 8'h04, 8'h00, 8'h00, 24'h000004, 0, 1024);
  endtask
  task automatic t_decode();
    rd(SRWCD_V20, `SRWCD_OP_RD512, 8'h21, 8'h48, 8'hD3, 8'h00, 24'h02D348, 0, 512);
    rd(SRWCD_V24, `SRWCD_OP_RD512, 8'h24, 8'h48, 8'hD3, 8'h00, 24'h32D348, 0, 512);
    rd(SRWCD_V24, `SRWCD_OP_RD512, 8'h21, 8'h48, 8'hD3, 8'h00, 24'h02D348, 0, 512);
  endtask
  task automatic t_refuse();
    rd(SRWCD_V24, `SRWCD_OP_RD1024, 8'h01, 8'h04, 8'h00, `SRWCD_RES_BAD_CMD, 24'h0, 0, 0);
    rd(SRWCD_V20, `SRWCD_OP_RD512, 8'h20, 8'h48, 8'hD3, `SRWCD_RES_BAD_CMD, 24'h0, 0, 0);
  endtask
  task automatic t_verify();
    wr(SRWCD_V24, `SRWCD_OP_WR512, 8'h01, 8'h30, 8'h00, 8'h00, 8'h00, 512, 0, 1);
    wr(SRWCD_V24, `SRWCD_OP_WR512, 8'h01, 8'h31, 8'h00, 8'h01, 8'h00, 512, 1, 1);
    crc_bad <= 1'b1;
    wr(SRWCD_V24, `SRWCD_OP_WR512, 8'h01, 8'h32, 8'h00, 8'h01, 8'hFF, 512, 1, 1);
    crc_bad <= 1'b0;
    wr(SRWCD_V20, `SRWCD_OP_WR512, 8'h01, 8'h33, 8'h00, 8'h00, 8'h00, 512, 1, 1);
    err_en <= 1'b1;
    wr(SRWCD_VTAPE, `SRWCD_OP_WR1024, 8'h01, 8'h05, 8'h00, 8'h01, 8'h00, 1024, 0, 1);
    err_en <= 1'b0;
  endtask
  task automatic t_merge();
    wr(SRWCD_V24, `SRWCD_OP_WR256A, 8'h01, 8'h60, 8'h00, 8'h00, 8'h00, 256, 1, 1);
    wr(SRWCD_V24, `SRWCD_OP_WR256B, 8'h01, 8'h62, 8'h00, 8'h00, 8'h00, 256, 1, 1);
    mp = 24'h000010;
    mlo = 128;
    wr(SRWCD_V24, `SRWCD_OP_WR128, 8'h01, 8'h41, 8'h00, 8'h00, 8'h00, 128, 1, 1);
    rd(SRWCD_V24, `SRWCD_OP_RD512, 8'h01, 8'h10, 8'h00, 8'h00, 24'h000010, 0, 512);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_sizes();
    t_decode();
    t_refuse();
    t_verify();
    t_merge();
    wrap_up();
  end
  // Limit sized well above the roughly 24k cycles of the run
  initial begin
    repeat (80000) @(posedge clock);
    bad_count++;
    wrap_up();
  end
endmodule
